/* shared/sfra_consts.vh */
// Constants for the signature, fuse and special-row access block.
`ifndef SFRA_CONSTS_VH
`define SFRA_CONSTS_VH
`define SFRA_SRAM_START      16'h6000
`define SFRA_SRAM_END        16'h7fff
`define SFRA_EEP_START       16'h1400
`define SFRA_EEP_END         16'h14ff
`define SFRA_SIG_PART0       5'h00
`define SFRA_SIG_PART2       5'h02
`define SFRA_SIG_GAIN_LO     5'h04
`define SFRA_SIG_GAIN_HI     5'h05
`define SFRA_SIG_OFFS_LO     5'h06
`define SFRA_SIG_OFFS_HI     5'h07
`define SFRA_SIG_SER_BASE    5'h10
`define SFRA_FUSE_WDT        4'h0
`define SFRA_FUSE_BOD        4'h1
`define SFRA_FUSE_OSC        4'h2
`define SFRA_FUSE_SYSA       4'h5
`define SFRA_FUSE_SYSB       4'h6
`define SFRA_FUSE_CODE       4'h7
`define SFRA_FUSE_BOOT       4'h8
`define SFRA_FUSE_PROT_LO    4'ha
`define SFRA_FUSE_PROT_HI    4'hb
`define SFRA_FUSE_VALID_MASK 16'h0de7
`define SFRA_PROT_KEY        12'hb45
`define SFRA_PROT_KEY_LSB    4
`define SFRA_PROT_LVL_ACCDIS 2'h2
`define SFRA_WDT_WIN_MSB     7
`define SFRA_WDT_WIN_LSB     4
`define SFRA_WDT_PER_MSB     3
`define SFRA_WDT_PER_LSB     0
`define SFRA_FUSE_RESET      8'h00
`define SFRA_TGT_WDT         3'h0
`define SFRA_TGT_BOD         3'h1
`define SFRA_TGT_OSC         3'h2
`define SFRA_TGT_SYSA        3'h3
`define SFRA_TGT_SYSB        3'h4
`define SFRA_TGT_CODE        3'h5
`define SFRA_TGT_BOOT        3'h6
`define SFRA_TGT_LAST        3'h6
`endif

/* hw/sfra_fuse_loader.v */
// Fuse-to-register copy sequencer run once after every reset.
`timescale 1ns/1ps
`include "sfra_consts.vh"
module sfra_fuse_loader (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire [63:0] fuse_flat_in,
  output reg  [7:0]  wdt_cfg_out,
  output reg  [7:0]  bod_cfg_out,
  output reg  [7:0]  osc_cfg_out,
  output reg  [7:0]  sys_a_cfg_out,
  output reg  [7:0]  sys_b_cfg_out,
  output reg  [7:0]  code_size_out,
  output reg  [7:0]  boot_size_out,
  output reg         load_done_out
);
  reg [2:0] idx_r;
  wire [7:0] cur_byte;
  assign cur_byte = fuse_flat_in[{idx_r, 3'b000} +: 8];
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      idx_r         <= 3'h0;
      load_done_out <= 1'b0;
      wdt_cfg_out   <= `SFRA_FUSE_RESET;
      bod_cfg_out   <= `SFRA_FUSE_RESET;
      osc_cfg_out   <= `SFRA_FUSE_RESET;
      sys_a_cfg_out <= `SFRA_FUSE_RESET;
      sys_b_cfg_out <= `SFRA_FUSE_RESET;
      code_size_out <= `SFRA_FUSE_RESET;
      boot_size_out <= `SFRA_FUSE_RESET;
    end else if (!load_done_out) begin
      case (idx_r)
        `SFRA_TGT_WDT: begin
          wdt_cfg_out[`SFRA_WDT_WIN_MSB:`SFRA_WDT_WIN_LSB] <= cur_byte[`SFRA_WDT_WIN_MSB:`SFRA_WDT_WIN_LSB];
          wdt_cfg_out[`SFRA_WDT_PER_MSB:`SFRA_WDT_PER_LSB] <= cur_byte[`SFRA_WDT_PER_MSB:`SFRA_WDT_PER_LSB];
        end
        `SFRA_TGT_BOD:  bod_cfg_out   <= cur_byte;
        `SFRA_TGT_OSC:  osc_cfg_out   <= cur_byte;
        `SFRA_TGT_SYSA: sys_a_cfg_out <= cur_byte;
        `SFRA_TGT_SYSB: sys_b_cfg_out <= cur_byte;
        `SFRA_TGT_CODE: code_size_out <= cur_byte;
        default:        boot_size_out <= cur_byte;
      endcase
      idx_r <= idx_r + 3'h1;
      if (idx_r == `SFRA_TGT_LAST) begin
        load_done_out <= 1'b1;
      end
    end
  end
endmodule // sfra_fuse_loader

/* hw/sfra_top.v */
// Special memory region access control, signature row and fuse store.
// Notes on behaviour
// - decode 8 KB SRAM at 0x6000-0x7FFF.
// - stack in SRAM; never fetch from SRAM.
// - 256-byte EEPROM window at 0x1400.
// - signature row is read-only for everyone.
// - three part-identifier bytes at 0x00-0x02.
// - gain word 0x04, signed offset 0x06.
// - sixteen serial bytes at 0x10-0x1F.
// - locked boot row only from boot code.
// - end-user row survives chip erase.
// - port may write end-user row when locked.
// - port reads of end-user row blocked when locked.
// - processor reads and writes end-user row.
// - anyone reads fuses; only port writes them.
// - copy fuses to targets after start-up.
// - fuse changes act only after reset.
// - watchdog fuse nibbles load window and period.
// - access-disabled level blocks port NV accesses.
`timescale 1ns/1ps
`include "sfra_consts.vh"
module sfra_top #(
  parameter [7:0]   PART_ID0     = 8'h5a,     // Arbitrary identity value.
  parameter [7:0]   PART_ID1     = 8'h01,     // Arbitrary identity value.
  parameter [7:0]   PART_ID2     = 8'h02,     // Arbitrary identity value.
  parameter [15:0]  GAIN_CAL     = 16'h0100,
  parameter [15:0]  OFFSET_CAL   = 16'h0000,
  parameter [127:0] SERIAL       = 128'h0f0e0d0c0b0a09080706050403020100,
  parameter [95:0]  FUSE_DEFAULT = 96'h0
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  // Processor data-space decode.
  input  wire [15:0] cpu_addr_in,
  input  wire        cpu_fetch_in,
  input  wire        cpu_in_boot_in,
  // Region access requests from either master.
  input  wire        acc_req_in,
  input  wire        acc_from_port_in,
  input  wire        acc_write_in,
  input  wire [2:0]  acc_region_in,
  input  wire [8:0]  acc_offset_in,
  input  wire [7:0]  acc_wdata_in,
  input  wire        acc_chip_erase_in,
  input  wire        dev_locked_in,
  output reg         sram_sel_out,
  output reg         eep_sel_out,
  output reg         fetch_fault_out,
  output reg         acc_done_out,
  output reg         acc_denied_out,
  output reg  [7:0]  acc_rdata_out,
  output reg         nv_write_out,
  output reg         user_row_erase_hold_out,
  output reg         prot_active_out,
  output wire [7:0]  wdt_cfg_out,
  output wire [7:0]  bod_cfg_out,
  output wire [7:0]  osc_cfg_out,
  output wire [7:0]  sys_a_cfg_out,
  output wire [7:0]  sys_b_cfg_out,
  output wire [7:0]  code_size_out,
  output wire [7:0]  boot_size_out,
  output wire        fuse_load_done_out
);
  localparam [2:0] REG_SIG   = 3'h0;
  localparam [2:0] REG_FUSE  = 3'h1;
  localparam [2:0] REG_BOOT  = 3'h2;
  localparam [2:0] REG_USER  = 3'h3;
  localparam [2:0] REG_EEP   = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Fuse store, flip-flops addressed by index.
  reg  [7:0]  fuse_mem_r [0:11];
  reg         prot_cap_r;
  wire [63:0] fuse_flat;
  wire [15:0] prot_word;
  wire [7:0]  sig_byte;
  wire        is_port_nv;
  wire        deny;
  reg  [7:0]  sig_sel;
  integer     k;

  assign prot_word = {fuse_mem_r[`SFRA_FUSE_PROT_HI], fuse_mem_r[`SFRA_FUSE_PROT_LO]};
  // Order matches the loader target index: wdt, bod, osc, sysa, sysb, code, boot.
  assign fuse_flat = {8'h00, fuse_mem_r[`SFRA_FUSE_BOOT], fuse_mem_r[`SFRA_FUSE_CODE],
                      fuse_mem_r[`SFRA_FUSE_SYSB], fuse_mem_r[`SFRA_FUSE_SYSA],
                      fuse_mem_r[`SFRA_FUSE_OSC], fuse_mem_r[`SFRA_FUSE_BOD],
                      fuse_mem_r[`SFRA_FUSE_WDT]};

  sfra_fuse_loader u_loader (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .fuse_flat_in  (fuse_flat),
    .wdt_cfg_out   (wdt_cfg_out),
    .bod_cfg_out   (bod_cfg_out),
    .osc_cfg_out   (osc_cfg_out),
    .sys_a_cfg_out (sys_a_cfg_out),
    .sys_b_cfg_out (sys_b_cfg_out),
    .code_size_out (code_size_out),
    .boot_size_out (boot_size_out),
    .load_done_out (fuse_load_done_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Signature row contents.
  always @* begin
    sig_sel = 8'h00;
    if (acc_offset_in[4:0] == `SFRA_SIG_PART0) begin
      sig_sel = PART_ID0;
    end else if (acc_offset_in[4:0] == `SFRA_SIG_PART0 + 5'h01) begin
      sig_sel = PART_ID1;
    end else if (acc_offset_in[4:0] == `SFRA_SIG_PART2) begin
      sig_sel = PART_ID2;
    end else if (acc_offset_in[4:0] == `SFRA_SIG_GAIN_LO) begin
      sig_sel = GAIN_CAL[7:0];
    end else if (acc_offset_in[4:0] == `SFRA_SIG_GAIN_HI) begin
      sig_sel = GAIN_CAL[15:8];
    end else if (acc_offset_in[4:0] == `SFRA_SIG_OFFS_LO) begin
      sig_sel = OFFSET_CAL[7:0];
    end else if (acc_offset_in[4:0] == `SFRA_SIG_OFFS_HI) begin
      sig_sel = OFFSET_CAL[15:8];
    end else if (acc_offset_in[4]) begin
      sig_sel = SERIAL[{acc_offset_in[3:0], 3'b000} +: 8];
    end
    // reserved offsets and beyond the row read zero.
    if (acc_offset_in[8:5] != 4'h0) begin
      sig_sel = 8'h00;
    end
  end
  assign sig_byte = sig_sel;

  ////////////////////////////////////////////////////////////////////////
  // Access decision.
  assign is_port_nv = acc_from_port_in && (acc_region_in != REG_SIG);
  // signature writes refused; processor fuse writes refused
  // locked boot row; locked port user-row reads; protection.
  assign deny = (acc_region_in == REG_SIG && acc_write_in)
             || (acc_region_in == REG_FUSE && acc_write_in && !acc_from_port_in)
             || (acc_region_in == REG_BOOT && dev_locked_in && (acc_from_port_in || !cpu_in_boot_in))
             || (acc_region_in == REG_USER && dev_locked_in && acc_from_port_in && !acc_write_in)
             || (prot_active_out && (is_port_nv || (acc_from_port_in && acc_chip_erase_in)))
             || (acc_region_in > REG_EEP);

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      sram_sel_out            <= 1'b0;
      eep_sel_out             <= 1'b0;
      fetch_fault_out         <= 1'b0;
      acc_done_out            <= 1'b0;
      acc_denied_out          <= 1'b0;
      acc_rdata_out           <= 8'h00;
      nv_write_out            <= 1'b0;
      user_row_erase_hold_out <= 1'b0;
      prot_active_out         <= 1'b0;
      prot_cap_r              <= 1'b1;
    end else begin
      sram_sel_out    <= (cpu_addr_in >= `SFRA_SRAM_START) && (cpu_addr_in <= `SFRA_SRAM_END);
      eep_sel_out     <= (cpu_addr_in >= `SFRA_EEP_START) && (cpu_addr_in <= `SFRA_EEP_END);
      fetch_fault_out <= cpu_fetch_in && (cpu_addr_in >= `SFRA_SRAM_START) && (cpu_addr_in <= `SFRA_SRAM_END);
      // Protection level is sampled once, after the fuse copy, and held until reset.
      if (prot_cap_r && fuse_load_done_out) begin
        prot_cap_r      <= 1'b0;
        prot_active_out <= dev_locked_in
                        && (prot_word[15:`SFRA_PROT_KEY_LSB] == `SFRA_PROT_KEY)
                        && (prot_word[1:0] == `SFRA_PROT_LVL_ACCDIS);
      end
      // end-user row kept out of chip erase.
      user_row_erase_hold_out <= acc_chip_erase_in;
      acc_done_out   <= acc_req_in;
      acc_denied_out <= acc_req_in && deny;
      // user-row writes pass to the controller.
      nv_write_out   <= acc_req_in && !deny && acc_write_in && (acc_region_in != REG_FUSE);
      if (acc_req_in && !deny && !acc_write_in) begin
        if (acc_region_in == REG_SIG) begin
          acc_rdata_out <= sig_byte;
        end else if (acc_region_in == REG_FUSE && acc_offset_in < 9'd12) begin
          acc_rdata_out <= fuse_mem_r[acc_offset_in[3:0]];
        end else begin
          acc_rdata_out <= 8'h00;
        end
      end else if (acc_req_in) begin
        acc_rdata_out <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fuse storage is nonvolatile, so reset must not clear it; otherwise a
  // programmed fuse could never reach its target on the next reset.
  initial begin
    for (k = 0; k < 12; k = k + 1) begin
      fuse_mem_r[k] = FUSE_DEFAULT[k * 8 +: 8];
    end
  end

  // Fuse storage writes from the port; reserved bits are forced to zero as a
  // guard, since a nonzero reserved bit from the programmer is its own fault.
  always @(posedge core_clk_in) begin
    if (!rst_in && acc_req_in && !deny && acc_write_in && acc_region_in == REG_FUSE
        && acc_offset_in < 9'd12) begin
      fuse_mem_r[acc_offset_in[3:0]] <= (acc_offset_in[3:0] == `SFRA_FUSE_PROT_LO) ? (acc_wdata_in & 8'hf3) :
                                        (acc_offset_in[3:0] == 4'h3 || acc_offset_in[3:0] == 4'h4 ||
                                         acc_offset_in[3:0] == 4'h9) ? 8'h00 : acc_wdata_in;
    end
  end
endmodule // sfra_top

/* dv/sfra_checker.sv */
// Port-level checks on the special region access block.
`timescale 1ns/1ps
`include "sfra_consts.vh"
module sfra_checker (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire [15:0] cpu_addr_in,
  input wire        cpu_fetch_in,
  input wire        cpu_in_boot_in,
  input wire        acc_req_in,
  input wire        acc_from_port_in,
  input wire        acc_write_in,
  input wire [2:0]  acc_region_in,
  input wire        acc_chip_erase_in,
  input wire        dev_locked_in,
  input wire        sram_sel_out,
  input wire        eep_sel_out,
  input wire        fetch_fault_out,
  input wire        acc_done_out,
  input wire        acc_denied_out,
  input wire        user_row_erase_hold_out,
  input wire [7:0]  wdt_cfg_out,
  input wire        fuse_load_done_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire in_sram = cpu_addr_in >= `SFRA_SRAM_START && cpu_addr_in <= `SFRA_SRAM_END;
  wire in_eep  = cpu_addr_in >= `SFRA_EEP_START && cpu_addr_in <= `SFRA_EEP_END;
  wire req_rd  = acc_req_in && !acc_write_in;
  // The copy takes several cycles, so done must stay low at first.
  sequence s_load_wait;
    !fuse_load_done_out [*3] ##[1:6] fuse_load_done_out;
  endsequence
  a_done_pulse: assert property (
    !$past(rst_in) |-> acc_done_out == $past(acc_req_in)) else $error("Done does not follow request.");
  a_sram_decode: assert property (
    !$past(rst_in) |-> sram_sel_out == $past(in_sram)) else $error("SRAM select wrong.");
  a_eep_decode: assert property (
    !$past(rst_in) |-> eep_sel_out == $past(in_eep)) else $error("EEPROM select wrong.");
  a_sram_fetch: assert property (
    !$past(rst_in) |-> fetch_fault_out == $past(in_sram && cpu_fetch_in)) else $error("Fetch fault wrong.");
  a_sig_readonly: assert property (
    acc_req_in && acc_write_in && acc_region_in == 3'h0 |=> acc_denied_out) else $error("Signature write taken.");
  a_fuse_cpu_wr: assert property (
    acc_req_in && acc_write_in && !acc_from_port_in && acc_region_in == 3'h1 |=> acc_denied_out)
    else $error("Processor fuse write taken.");
  a_boot_locked: assert property (
    acc_req_in && acc_region_in == 3'h2 && dev_locked_in && (acc_from_port_in || !cpu_in_boot_in)
    |=> acc_denied_out) else $error("Locked boot row access taken.");
  a_user_port_rd: assert property (
    req_rd && acc_from_port_in && dev_locked_in && acc_region_in == 3'h3 |=> acc_denied_out)
    else $error("Locked port row read taken.");
  a_erase_hold: assert property (
    !$past(rst_in) |-> user_row_erase_hold_out == $past(acc_chip_erase_in)) else $error("Erase hold wrong.");
  a_load_seq: assert property (
    $fell(rst_in) |-> s_load_wait) else $error("Fuse load timing wrong.");
  a_cfg_stable: assert property (
    fuse_load_done_out && $past(fuse_load_done_out) |-> $stable(wdt_cfg_out)) else $error("Config moved.");
endmodule // sfra_checker
bind sfra_top sfra_checker u_chk (.core_clk_in, .rst_in, .cpu_addr_in, .cpu_fetch_in, .cpu_in_boot_in,
  .acc_req_in, .acc_from_port_in, .acc_write_in, .acc_region_in, .acc_chip_erase_in, .dev_locked_in,
  .sram_sel_out, .eep_sel_out, .fetch_fault_out, .acc_done_out, .acc_denied_out,
  .user_row_erase_hold_out, .wdt_cfg_out, .fuse_load_done_out);

/* dv/sfra_prog_model.sv */
// External programmer model that forms legal fuse bytes.
`timescale 1ns/1ps
module sfra_prog_model (
  input  wire [3:0]  fuse_off_in,
  input  wire [7:0]  raw_in,
  output reg  [7:0]  fuse_byte_out,
  output wire [15:0] prot_word_out
);
  always @* begin
    case (fuse_off_in)
      4'h3, 4'h4, 4'h9: fuse_byte_out = 8'h00;
      4'ha: fuse_byte_out = raw_in & 8'hf3;
      default: fuse_byte_out = raw_in;
    endcase
  end
  assign prot_word_out = 16'hb452;
endmodule // sfra_prog_model

/* dv/tb_top.sv */
// Self-checking bench for the special region access block.
`timescale 1ns/1ps
`include "sfra_consts.vh"
module tb_top;
  localparam [7:0]   P0  = 8'h3c; // Arbitrary identity value.
  localparam [7:0]   P1  = 8'h4d; // Arbitrary identity value.
  localparam [7:0]   P2  = 8'h6e; // Arbitrary identity value.
  localparam [15:0]  GN  = 16'h8123;
  localparam [15:0]  OF  = 16'hfe10;
  localparam [127:0] SER = 128'h1f2e3d4c5b6a79880796a5b4c3d2e1f0;
  localparam [127:0] COR = 128'h6000_5fff_7fff_8000_1400_13ff_14ff_1500;
  reg        core_clk_in = 1'b0, rst_in = 1'b1, cpu_fetch_in = 1'b0, cpu_in_boot_in = 1'b0;
  reg        acc_req_in = 1'b0, acc_from_port_in = 1'b0, acc_write_in = 1'b0;
  reg        acc_chip_erase_in = 1'b0, dev_locked_in = 1'b0;
  reg [15:0] cpu_addr_in = 16'h0000, lf = 16'h0039, a;
  reg [2:0]  acc_region_in = 3'h0;
  reg [8:0]  acc_offset_in = 9'h000;
  reg [7:0]  acc_wdata_in = 8'h00, pm_raw = 8'h00, v;
  reg [3:0]  pm_off = 4'h0;
  wire       sram_sel_out, eep_sel_out, fetch_fault_out, acc_done_out, acc_denied_out, nv_write_out;
  wire       user_row_erase_hold_out, prot_active_out, fuse_load_done_out;
  wire [7:0] acc_rdata_out, wdt_cfg_out, bod_cfg_out, osc_cfg_out, sys_a_cfg_out, sys_b_cfg_out;
  wire [7:0] code_size_out, boot_size_out, pm_byte;
  wire [15:0] pm_prot;
  integer    bad_count = 0, check_count = 0, i, n;
  always #20 core_clk_in = ~core_clk_in;
  sfra_top #(.PART_ID0(P0), .PART_ID1(P1), .PART_ID2(P2), .GAIN_CAL(GN), .OFFSET_CAL(OF), .SERIAL(SER)) u_dut (.*);
  sfra_prog_model u_prog (.fuse_off_in(pm_off), .raw_in(pm_raw), .fuse_byte_out(pm_byte), .prot_word_out(pm_prot));
  ////////////////////////////////////////////////////////////////////////////////
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [7:0] sig_exp(input [4:0] o);
    case (o)
      5'h00: sig_exp = P0;
      5'h01: sig_exp = P1;
      5'h02: sig_exp = P2;
      5'h04: sig_exp = GN[7:0];
      5'h05: sig_exp = GN[15:8];
      5'h06: sig_exp = OF[7:0];
      5'h07: sig_exp = OF[15:8];
      default: sig_exp = o[4] ? SER[o[3:0] * 8 +: 8] : 8'h00;
    endcase
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A second reset is the only way fuse edits reach the targets.
  task do_reset;
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (n = 0; n < 20 && fuse_load_done_out !== 1'b1; n = n + 1) begin
      @(posedge core_clk_in);
      #1;
    end
    if (n == 20) begin
      bad_count = bad_count + 1;
      conclude;
    end
    @(posedge core_clk_in);
    #1;
  endtask
  task acc(input p, input w, input [2:0] rg, input [8:0] off, input [7:0] d);
    @(posedge core_clk_in);
    acc_req_in       <= 1'b1;
    acc_from_port_in <= p;
    acc_write_in     <= w;
    acc_region_in    <= rg;
    acc_offset_in    <= off;
    acc_wdata_in     <= d;
    @(posedge core_clk_in);
    acc_req_in <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset;
    chk(wdt_cfg_out, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      lf = lfsr(lf);
      a = (i < 8) ? COR[(7 - i) * 16 +: 16] : lf;
      @(posedge core_clk_in);
      cpu_addr_in  <= a;
      cpu_fetch_in <= lf[1] | i[0];
      @(posedge core_clk_in);
      #1;
      chk(sram_sel_out, a >= 16'h6000 && a <= 16'h7fff);
      chk(eep_sel_out, a[15:8] == 8'h14);
      chk(fetch_fault_out, cpu_fetch_in && a >= 16'h6000 && a <= 16'h7fff);
    end
    for (i = 0; i < 32; i = i + 1) begin
      acc(i[0], 1'b0, 3'h0, i[8:0], 8'h00);
      chk(acc_rdata_out, sig_exp(i[4:0]));
    end
    acc(1'b1, 1'b1, 3'h0, 9'h010, ~sig_exp(5'h10));
    chk(acc_denied_out, 1'b1);
    chk(nv_write_out, 1'b0);
    acc(1'b0, 1'b0, 3'h0, 9'h010, 8'h00);
    chk(acc_rdata_out, sig_exp(5'h10));
    lf = lfsr(lf);
    pm_off = `SFRA_FUSE_WDT;
    pm_raw = lf[7:0] | 8'h11;
    v = lf[7:0] | 8'h11;
    #1;
    acc(1'b0, 1'b1, 3'h1, 9'h000, pm_byte);
    chk(acc_denied_out, 1'b1);
    acc(1'b1, 1'b1, 3'h1, 9'h000, pm_byte);
    chk(acc_denied_out, 1'b0);
    acc(1'b0, 1'b0, 3'h1, 9'h000, 8'h00);
    chk(acc_rdata_out, v);
    chk(wdt_cfg_out, 8'h00);
    do_reset;
    chk(wdt_cfg_out, v);
    @(posedge core_clk_in);
    dev_locked_in <= 1'b1;
    acc(1'b0, 1'b0, 3'h2, 9'h000, 8'h00);
    chk(acc_denied_out, 1'b1);
    @(posedge core_clk_in);
    cpu_in_boot_in <= 1'b1;
    acc(1'b0, 1'b0, 3'h2, 9'h000, 8'h00);
    chk(acc_denied_out, 1'b0);
    acc(1'b1, 1'b1, 3'h3, 9'h1ff, 8'ha5);
    chk(acc_denied_out, 1'b0);
    chk(nv_write_out, 1'b1);
    acc(1'b1, 1'b0, 3'h3, 9'h1ff, 8'h00);
    chk({acc_denied_out, acc_rdata_out}, 9'h100);
    acc(1'b0, 1'b0, 3'h3, 9'h1ff, 8'h00);
    chk(acc_denied_out, 1'b0);
    @(posedge core_clk_in);
    acc_chip_erase_in <= 1'b1;
    acc(1'b1, 1'b1, 3'h1, 9'h00a, pm_prot[7:0]);
    acc_chip_erase_in <= 1'b0;
    acc(1'b1, 1'b1, 3'h1, 9'h00b, pm_prot[15:8]);
    do_reset;
    chk(prot_active_out, 1'b1);
    acc(1'b1, 1'b0, 3'h4, 9'h000, 8'h00);
    chk(acc_denied_out, 1'b1);
    acc(1'b1, 1'b1, 3'h3, 9'h000, 8'h00);
    chk(acc_denied_out, 1'b1);
    acc(1'b0, 1'b0, 3'h4, 9'h000, 8'h00);
    chk(acc_denied_out, 1'b0);
    conclude;
  end
endmodule // tb_top
